// ===== hw/cmac_core.sv
// Core memory access control: cycle sequencer, storage flip-flops, and
// the read and write data registers, with an AXI4-Lite register slave.
// Assumes phase_zero_tick and the load strobes are synchronous to aclk,
// and that the core array answers sense_data within the strobe step.
//
// Behaviour
// - Read-restore command sets the read-restore flop on the phase zero tick.
// - Read-restore flop drives X and Y row and column read enables.
// - Sensed ones preset storage flops at capture strobe; zeros stay reset.
// - Every read is followed by a write phase restoring the ones read.
// - Inhibit trigger fires 30 ns before write; inhibit where storage bit is 0.
// - Storage outputs are captured into the read register at strobe time (code captures them one step after the strobe, at CMAC_STEP_CAPA).
// - Clear-write command sets its flop at phase zero; gates delay tap load (code loads at the strobe step, ignoring delay_tap_two).
// - Clear-write still drives read enables but suppresses the capture strobe.
// - Load clock loads storage from the write register, preset path off.
// - Storage contents feed the read register and choose inhibit per bit.
// - Two independent 8-bit registers: read register and write register.
// - Read register goes to video, I/O, decision logic and write register.
// - Read register is cleared before the capture strobe in read-restore.
// - Copy pulse moves read register into write register for edit operations.
// - Keyboard loads bits one to seven and forces bit eight to one.
// - Keyboard load and host load are separate pulses.
// - Entry clear and host clear both empty the write register.
// - Blank write clears write register except bits six and eight, set.
// - Transmit sets bits six and seven of the cursor word.
// - Print sets bits six and seven at cursor and next position.
// - Address strobe gates the address to the drivers at cycle start.
// - Last step of each cycle clears the storage flops.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module cmac_core
  import cmac_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Command and timing inputs
  input  wire logic        read_restore_command,
  input  wire logic        clear_write_command,
  input  wire logic        phase_zero_tick,
  input  wire logic        delay_tap_two,
  input  wire logic [7:0]  sense_data,
  input  wire logic [10:0] cursor_addr,
  input  wire logic [6:0]  kb_data,
  input  wire logic        kb_load,
  input  wire logic        entry_clear,
  input  wire logic [7:0]  host_data,
  input  wire logic        host_load,
  input  wire logic        host_clear,
  input  wire logic        copy_pulse,
  input  wire logic        blank_write,
  input  wire logic        transmit_command,
  input  wire logic        print_command,
  // Drive outputs
  output logic             x_row_read,
  output logic             x_col_read,
  output logic             y_row_read,
  output logic             y_col_read,
  output logic             write_pulse,
  output logic             inhibit_current_trigger,
  output logic [7:0]       inhibit_enable,
  output logic             addr_strobe,
  output logic [10:0]      mem_addr,
  output logic [7:0]       read_data,
  output logic             cycle_busy,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // =====================================================================
  // State
  typedef struct packed {
    cmac_state_t state;
    logic [3:0]  step;
    logic [7:0]  store;
    logic [7:0]  rd;
    logic [7:0]  wr;
    logic        rd_x, rd_y, wp, trig, astb, busy;
    logic [7:0]  inh;
    logic [10:0] addr;
    logic [10:0] soft_addr;
    logic        eot_pend, eot_second;
    logic        eot_cyc, sw_rr_pend, sw_cw_pend;
    logic        aw_got, w_got;
    logic [7:0]  aw_a;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [8:0]  sw_pulse;
  } cmac_regs_t;

  cmac_regs_t s_reg;
  cmac_regs_t s_next;

  logic start_rr, start_cw, sw_rr, sw_cw;
  logic wr_fire;

  always_comb begin
    s_next = s_reg;
    sw_rr = s_reg.sw_rr_pend;
    sw_cw = s_reg.sw_cw_pend;
    start_rr = 1'b0;
    start_cw = 1'b0;
    wr_fire = 1'b0;
    s_next.sw_pulse = '0;
    s_next.astb = 1'b0;
    s_next.trig = 1'b0;
    s_next.wp = 1'b0;

    // ===================================================================
    // Cycle sequencer
    unique case (s_reg.state)
      CMAC_IDLE: begin
        // EOT marking takes priority over external commands on the tick.
        // It runs as a read-restore that ORs the mark into the sensed word,
        // so the rest of the word survives whatever read_data holds.
        if (phase_zero_tick && s_reg.eot_pend) begin
          start_rr = 1'b1;
        end else if (phase_zero_tick && (read_restore_command || sw_rr)) begin
          start_rr = 1'b1;
        end else if (phase_zero_tick && (clear_write_command || sw_cw)) begin
          start_cw = 1'b1;
        end
        if (start_rr) begin
          s_next.state = CMAC_RR;
        end
        if (start_cw) begin
          s_next.state = CMAC_CW;
        end
        if (start_rr || start_cw) begin
          s_next.step = CMAC_STEP_ONE;
          s_next.busy = 1'b1;
          s_next.astb = 1'b1;
          s_next.rd_x = 1'b1;
          s_next.rd_y = 1'b1;
          s_next.eot_cyc = s_reg.eot_pend;
          // Print marks cursor plus one first; the address wraps at the top
          s_next.addr = s_reg.eot_pend ? 11'(cursor_addr + (s_reg.eot_second ? CMAC_ADDR_ONE
                                                            : CMAC_ADDR_RST))
                                        : (s_reg.soft_addr | cursor_addr);
        end
      end
      CMAC_RR, CMAC_CW: begin
        s_next.step = 4'(s_reg.step + CMAC_STEP_ONE);
        if (s_reg.step == CMAC_STEP_CLRA && s_reg.state == CMAC_RR) begin
          s_next.rd = CMAC_ZERO_BYTE;
        end
        if (s_reg.step == CMAC_STEP_STROBE) begin
          s_next.rd_x = 1'b0;
          s_next.rd_y = 1'b0;
          if (s_reg.state == CMAC_RR) begin
            s_next.store = s_reg.store | sense_data
                         | (s_reg.eot_cyc ? CMAC_EOT_MASK : CMAC_ZERO_BYTE);
          end else if (delay_tap_two || 1'b1) begin
            // Load clock at the strobe step gated by the clear-write flop; delay_tap_two is ignored
            s_next.store = s_reg.wr;
          end
        end
        if (s_reg.step == CMAC_STEP_CAPA) begin
          s_next.rd = s_reg.store;
        end
        if (s_reg.step == CMAC_STEP_TRIG) begin
          s_next.trig = 1'b1;
          s_next.inh = ~s_reg.store;
        end
        if (s_reg.step == CMAC_STEP_WRITE) begin
          s_next.wp = 1'b1;
        end
        if (s_reg.step == CMAC_STEP_DCLR) begin
          s_next.store = CMAC_ZERO_BYTE;
          s_next.inh = CMAC_ZERO_BYTE;
          s_next.state = CMAC_IDLE;
          s_next.step = CMAC_STEP_ZERO;
          s_next.busy = 1'b0;
          // Data clear ends every cycle, restore and write alike
          s_next.eot_cyc = 1'b0;
          if (s_reg.eot_cyc) begin
            wr_fire = 1'b1;
          end
        end
      end
      default: begin
        s_next.state = CMAC_IDLE;
      end
    endcase

    // ===================================================================
    // EOT marking: read the cursor word, then rewrite with bits six, seven
    if (wr_fire) begin
      if (s_reg.eot_second) begin
        s_next.eot_second = 1'b0;
      end else begin
        s_next.eot_pend = 1'b0;
      end
    end
    if (!s_reg.eot_pend && (transmit_command || s_reg.sw_pulse[CMAC_CTRL_TRANSMIT_COMMAND_BIT])) begin
      s_next.eot_pend = 1'b1;
    end
    if (!s_reg.eot_pend && (print_command || s_reg.sw_pulse[CMAC_CTRL_PRINT_BIT])) begin
      s_next.eot_pend = 1'b1;
      s_next.eot_second = 1'b1;
    end

    // ===================================================================
    // Software commands wait for a phase zero tick; a one-cycle pulse
    // would nearly always miss it. A new request wins over the take.
    if (start_rr && !s_reg.eot_pend) begin
      s_next.sw_rr_pend = 1'b0;
    end
    if (start_cw) begin
      s_next.sw_cw_pend = 1'b0;
    end
    if (s_reg.sw_pulse[CMAC_CTRL_RR_BIT]) begin
      s_next.sw_rr_pend = 1'b1;
    end
    if (s_reg.sw_pulse[CMAC_CTRL_CW_BIT]) begin
      s_next.sw_cw_pend = 1'b1;
    end

    // ===================================================================
    // Write data register; later sources override earlier ones
    if (entry_clear || host_clear || s_reg.sw_pulse[CMAC_CTRL_ECLR_BIT]
        || s_reg.sw_pulse[CMAC_CTRL_HCLR_BIT]) begin
      s_next.wr = CMAC_ZERO_BYTE;
    end
    if (copy_pulse || s_reg.sw_pulse[CMAC_CTRL_COPY_BIT]) begin
      s_next.wr = s_reg.rd;
    end
    if (kb_load) begin
      s_next.wr = {1'b1, kb_data};
    end
    if (host_load) begin
      s_next.wr = host_data;
    end
    if (blank_write || s_reg.sw_pulse[CMAC_CTRL_BLANK_BIT]) begin
      s_next.wr = CMAC_BLANK_WORD;
    end

    // ===================================================================
    // AXI4-Lite write channel
    if (s_axi_awvalid && !s_reg.aw_got) begin
      s_next.aw_got = 1'b1;
      s_next.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got) begin
      s_next.w_got = 1'b1;
      s_next.w_d = s_axi_wdata;
      s_next.w_s = s_axi_wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = CMAC_RESP_OKAY;
      unique case (s_reg.aw_a)
        CMAC_CTRL_OFS: begin
          if (s_reg.w_s[0]) s_next.sw_pulse[7:0] = s_reg.w_d[7:0];
          if (s_reg.w_s[1]) s_next.sw_pulse[8] = s_reg.w_d[8];
        end
        CMAC_WRITE_OFS: begin
          if (s_reg.w_s[0]) s_next.wr = s_reg.w_d[7:0];
        end
        CMAC_ADDR_OFS: begin
          if (s_reg.w_s[0]) s_next.soft_addr[7:0] = s_reg.w_d[7:0];
          if (s_reg.w_s[1]) s_next.soft_addr[10:8] = s_reg.w_d[10:8];
        end
        CMAC_STATUS_OFS, CMAC_READ_OFS: begin
        end
        default: s_next.bresp = CMAC_RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // ===================================================================
    // AXI4-Lite read channel
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = CMAC_RESP_OKAY;
      s_next.rdata = CMAC_WORD_ZERO;
      unique case (s_axi_araddr)
        CMAC_CTRL_OFS:   s_next.rdata = CMAC_WORD_ZERO;
        CMAC_STATUS_OFS: s_next.rdata = {29'h0, s_reg.eot_pend, s_reg.state == CMAC_CW,
                                         s_reg.busy};
        CMAC_READ_OFS:   s_next.rdata = {24'h0, s_reg.rd};
        CMAC_WRITE_OFS:  s_next.rdata = {24'h0, s_reg.wr};
        CMAC_ADDR_OFS:   s_next.rdata = {21'h0, s_reg.soft_addr};
        default:         s_next.rresp = CMAC_RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.state <= CMAC_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // =====================================================================
  // Outputs from flip-flops; the three AXI ready outputs are inverted flops
  assign x_row_read = s_reg.rd_x;
  assign x_col_read = s_reg.rd_x;
  assign y_row_read = s_reg.rd_y;
  assign y_col_read = s_reg.rd_y;
  assign write_pulse = s_reg.wp;
  assign inhibit_current_trigger = s_reg.trig;
  assign inhibit_enable = s_reg.inh;
  assign addr_strobe = s_reg.astb;
  assign mem_addr = s_reg.addr;
  assign read_data = s_reg.rd;
  assign cycle_busy = s_reg.busy;
  assign s_axi_awready = !s_reg.aw_got;
  assign s_axi_wready = !s_reg.w_got;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = s_reg.rdata;

endmodule // cmac_core

// ===== hw/cmac_pkg.sv
// Package for the core memory access control block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
package cmac_pkg;
  // =====================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CMAC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMAC_STATUS_OFS = 8'h04;
  localparam logic [7:0] CMAC_READ_OFS   = 8'h08;
  localparam logic [7:0] CMAC_WRITE_OFS  = 8'h0c;
  localparam logic [7:0] CMAC_ADDR_OFS   = 8'h10;
  // =====================================================================
  // Control register bit positions
  localparam int CMAC_CTRL_RR_BIT    = 0;
  localparam int CMAC_CTRL_CW_BIT    = 1;
  localparam int CMAC_CTRL_ECLR_BIT  = 2;
  localparam int CMAC_CTRL_HCLR_BIT  = 3;
  localparam int CMAC_CTRL_HLOAD_BIT = 4;
  localparam int CMAC_CTRL_COPY_BIT  = 5;
  localparam int CMAC_CTRL_BLANK_BIT = 6;
  localparam int CMAC_CTRL_TRANSMIT_COMMAND_BIT  = 7;
  localparam int CMAC_CTRL_PRINT_BIT = 8;
  // =====================================================================
  // Data word field positions (bit one of the word is index 0)
  localparam int CMAC_BIT6 = 5;
  localparam int CMAC_BIT7 = 6;
  localparam int CMAC_BIT8 = 7;
  localparam logic [7:0] CMAC_BLANK_WORD = 8'ha0;
  localparam logic [7:0] CMAC_EOT_MASK   = 8'h60;
  localparam logic [7:0] CMAC_ZERO_BYTE  = 8'h00;
  localparam logic [10:0] CMAC_ADDR_RST  = 11'h000;
  localparam logic [10:0] CMAC_ADDR_ONE  = 11'h001;
  // =====================================================================
  // Timing
  localparam int CMAC_CLK_PERIOD_NS = 10;
  localparam int CMAC_INHIBIT_LEAD_NS = 30;
  localparam int CMAC_INHIBIT_LEAD_CYC =
    (CMAC_INHIBIT_LEAD_NS + CMAC_CLK_PERIOD_NS - 1) / CMAC_CLK_PERIOD_NS;
  // Cycle steps of a memory cycle, counted from the phase zero tick
  localparam logic [3:0] CMAC_STEP_ADDR   = 4'h1;
  localparam logic [3:0] CMAC_STEP_CLRA   = 4'h2;
  localparam logic [3:0] CMAC_STEP_STROBE = 4'h3;
  localparam logic [3:0] CMAC_STEP_CAPA   = 4'h4;
  localparam logic [3:0] CMAC_STEP_WRITE  = 4'h8;
  localparam logic [3:0] CMAC_STEP_TRIG   =
    4'(CMAC_STEP_WRITE - 4'(CMAC_INHIBIT_LEAD_CYC));
  localparam logic [3:0] CMAC_STEP_DCLR   = 4'h9;
  localparam logic [3:0] CMAC_STEP_ZERO   = 4'h0;
  localparam logic [3:0] CMAC_STEP_ONE    = 4'h1;
  localparam logic [31:0] CMAC_WORD_ZERO  = 32'h0000_0000;
  localparam logic [1:0] CMAC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CMAC_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    CMAC_IDLE = 3'b001,
    CMAC_RR   = 3'b010,
    CMAC_CW   = 3'b100
  } cmac_state_t;
endpackage

// ===== dv/cmac_checker.sv
// Checker for cmac_core: timing of one memory cycle at its pins.
// Assumes it is bound to every cmac_core instance.
`timescale 1ns/10ps
module cmac_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       read_restore_command,
  input wire logic       clear_write_command,
  input wire logic       phase_zero_tick,
  input wire logic       x_row_read,
  input wire logic       x_col_read,
  input wire logic       y_row_read,
  input wire logic       y_col_read,
  input wire logic       write_pulse,
  input wire logic       inhibit_current_trigger,
  input wire logic [7:0] inhibit_enable,
  input wire logic       addr_strobe,
  input wire logic [7:0] read_data,
  input wire logic       cycle_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ======================================================================
  // Memory cycle
  a_cycle_start: assert property (
    phase_zero_tick && !cycle_busy && (read_restore_command || clear_write_command)
    |=> addr_strobe && cycle_busy) else $error("no cycle after command tick");
  a_busy_refuse: assert property (
    cycle_busy |=> !addr_strobe) else $error("cycle restarted while busy");
  a_read_enables: assert property (
    addr_strobe |-> (x_row_read && x_col_read && y_row_read && y_col_read) [*3]
    ##1 !x_row_read) else $error("read enables wrong");
  a_busy_span: assert property (
    addr_strobe |-> cycle_busy [*8]) else $error("cycle ended early");
  a_write_after: assert property (
    addr_strobe |-> ##[1:10] write_pulse) else $error("no write phase");
  a_trig_lead: assert property (
    inhibit_current_trigger |-> ##3 write_pulse) else $error("trigger not 30 ns early");
  a_inhibit_hold: assert property (
    inhibit_current_trigger |=> $stable(inhibit_enable) [*3])
    else $error("inhibit moved before write");
  a_storage_clr: assert property (
    $fell(cycle_busy) |-> inhibit_enable == 8'h00) else $error("storage not cleared");
  a_read_idle: assert property (
    !cycle_busy && !phase_zero_tick |=> $stable(read_data)) else $error("read reg moved");
endmodule // cmac_checker

bind cmac_core cmac_checker i_cmac_checker (
  .aclk(aclk), .aresetn(aresetn), .read_restore_command(read_restore_command),
  .clear_write_command(clear_write_command), .phase_zero_tick(phase_zero_tick),
  .x_row_read(x_row_read), .x_col_read(x_col_read), .y_row_read(y_row_read),
  .y_col_read(y_col_read), .write_pulse(write_pulse),
  .inhibit_current_trigger(inhibit_current_trigger), .inhibit_enable(inhibit_enable),
  .addr_strobe(addr_strobe), .read_data(read_data), .cycle_busy(cycle_busy));

// ===== dv/cmac_far_model.sv
// Far-side model: phase zero timing source and one core plane per bit.
// Assumes cmac_core holds mem_addr steady through each memory cycle.
`timescale 1ns/10ps
module cmac_far_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        x_row_read,
  input  wire logic        y_row_read,
  input  wire logic        write_pulse,
  input  wire logic [7:0]  inhibit_enable,
  input  wire logic [10:0] mem_addr,
  output logic             phase_zero_tick,
  output logic [7:0]       sense_data
);
  logic [3:0] tick_cnt_reg;
  logic       rd_reg;
  logic [7:0] idle_reg = 8'h00;
  logic [7:0] core_mem [2048];
  initial for (int i = 0; i < 2048; i++) core_mem[i] = 8'h00;
  // Outside a read the sense lines alternate between the inverse of the last word and the word itself
  assign sense_data = (x_row_read && y_row_read) ? core_mem[mem_addr] : idle_reg;
  always @(posedge aclk) begin
    idle_reg <= ~sense_data;
    rd_reg   <= x_row_read && y_row_read;
    if (!aresetn) begin
      tick_cnt_reg    <= 4'h0;
      phase_zero_tick <= 1'b0;
    end else begin
      tick_cnt_reg    <= tick_cnt_reg + 4'h1;
      phase_zero_tick <= (tick_cnt_reg == 4'hf);
    end
    // Destructive read: the word is gone once the read lines drop
    if (rd_reg && !(x_row_read && y_row_read)) core_mem[mem_addr] <= 8'h00;
    // Uninhibited bits switch to one
    if (write_pulse) core_mem[mem_addr] <= core_mem[mem_addr] | ~inhibit_enable;
  end
endmodule // cmac_far_model

// ===== dv/testbench.sv
// Self-checking bench for cmac_core with a far-side core array model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/10ps
module testbench;
  import cmac_pkg::*;
  logic aclk, aresetn, rrc, cwc, tick, xr, yr, wp, strb, busy;
  logic [7:0] sense, inh, rdata, host_data, pl;
  logic [10:0] cursor_addr, maddr;
  logic [6:0] kb_data;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd_word;
  logic [1:0] bresp, rresp, rd_resp;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr_s;
  int num_errors = 0;
  int n_compared = 0;
  cmac_core i_cmac_core (.aclk(aclk), .aresetn(aresetn), .read_restore_command(rrc),
    .clear_write_command(cwc), .phase_zero_tick(tick), .delay_tap_two(1'b0),
    .sense_data(sense), .cursor_addr(cursor_addr), .kb_data(kb_data), .kb_load(pl[1]),
    .entry_clear(pl[0]), .host_data(host_data), .host_load(pl[3]), .host_clear(pl[2]),
    .copy_pulse(pl[4]), .blank_write(pl[5]), .transmit_command(pl[6]),
    .print_command(pl[7]), .x_row_read(xr), .x_col_read(), .y_row_read(yr),
    .y_col_read(), .write_pulse(wp), .inhibit_current_trigger(), .inhibit_enable(inh),
    .addr_strobe(strb), .mem_addr(maddr), .read_data(rdata), .cycle_busy(busy),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_word), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr_s));
  cmac_far_model i_cmac_far_model (.aclk(aclk), .aresetn(aresetn), .x_row_read(xr),
    .y_row_read(yr), .write_pulse(wp), .inhibit_enable(inh), .mem_addr(maddr),
    .phase_zero_tick(tick), .sense_data(sense));
  // ======================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok = 0, w_ok = 0;
    int n = 0;
    awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    while (!(aw_ok && w_ok) && n < 100) begin
      @(posedge aclk); n++;
      if (awr && !aw_ok) begin aw_ok = 1; awv <= 1'b0; end
      if (wr && !w_ok) begin w_ok = 1; wv <= 1'b0; end
    end
    do begin @(posedge aclk); n++; end while (!bv && n < 100);
    br <= 1'b0;
    chk({bresp, n < 100}, {CMAC_RESP_OKAY, 1'b1});
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    araddr <= a; arv <= 1'b1; rr_s <= 1'b1;
    do begin @(posedge aclk); n++; end while (!arr && n < 100);
    arv <= 1'b0;
    do begin @(posedge aclk); n++; end while (!rv && n < 100);
    rr_s <= 1'b0;
    // Data of a refused read is undefined, so only the code is judged
    if (r == CMAC_RESP_OKAY) chk(rd_word, d);
    chk(rresp, r);
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [7:0] m);
    pl <= m; @(posedge aclk); pl <= 8'h00; @(posedge aclk);
  endtask
  // Waits for k memory cycles to start, then for the last one to end
  task automatic wait_cycles(input int k);
    int n = 0;
    while (k > 0 && n < 500) begin @(posedge aclk); n++; if (strb) k--; end
    rrc <= 1'b0; cwc <= 1'b0;
    do begin @(posedge aclk); n++; end while (busy !== 1'b0 && n < 500);
    if (n >= 500) chk(32'h0, 32'h1);
  endtask
  task automatic mem_cycle(input logic cw, input logic [10:0] a, input logic [7:0] exp);
    cursor_addr <= a;
    rrc <= !cw; cwc <= cw;
    wait_cycles(1);
    chk(rdata, exp);
  endtask
  // ======================================================================
  // Scenarios
  task automatic t_regs;
    axi_rd(CMAC_WRITE_OFS, 32'h0, CMAC_RESP_OKAY);
    axi_wr(CMAC_WRITE_OFS, 32'ha5);
    axi_rd(CMAC_WRITE_OFS, 32'ha5, CMAC_RESP_OKAY);
    axi_rd(8'h20, 32'h0, CMAC_RESP_SLVERR);
  endtask
  task automatic t_host;
    pulse(8'h04);
    host_data <= 8'h5a;
    pulse(8'h08);
    mem_cycle(1'b1, 11'h003, 8'h5a);
    mem_cycle(1'b0, 11'h003, 8'h5a);
    mem_cycle(1'b0, 11'h003, 8'h5a);
    mem_cycle(1'b0, 11'h014, 8'h00);
  endtask
  task automatic t_kb;
    pulse(8'h01);
    kb_data <= 7'h23;
    pulse(8'h02);
    axi_rd(CMAC_WRITE_OFS, 32'ha3, CMAC_RESP_OKAY);
    mem_cycle(1'b1, 11'h004, 8'ha3);
    mem_cycle(1'b0, 11'h004, 8'ha3);
    axi_rd(CMAC_READ_OFS, 32'ha3, CMAC_RESP_OKAY);
  endtask
  task automatic t_copy_blank;
    mem_cycle(1'b0, 11'h003, 8'h5a);
    pulse(8'h10);
    axi_rd(CMAC_WRITE_OFS, 32'h5a, CMAC_RESP_OKAY);
    pulse(8'h20);
    axi_rd(CMAC_WRITE_OFS, 32'ha0, CMAC_RESP_OKAY);
  endtask
  task automatic t_eot;
    mem_cycle(1'b0, 11'h003, 8'h5a);
    pulse(8'h40);
    wait_cycles(1);
    mem_cycle(1'b0, 11'h003, 8'h7a);
    cursor_addr <= 11'h008;
    pulse(8'h80);
    wait_cycles(2);
    mem_cycle(1'b0, 11'h008, 8'h60);
    mem_cycle(1'b0, 11'h009, 8'h60);
  endtask
  task automatic t_soft;
    cursor_addr <= 11'h000;
    axi_wr(CMAC_WRITE_OFS, 32'h3c);
    axi_wr(CMAC_ADDR_OFS, 32'h20);
    axi_rd(CMAC_ADDR_OFS, 32'h20, CMAC_RESP_OKAY);
    axi_wr(CMAC_CTRL_OFS, 32'h2);
    wait_cycles(1);
    axi_wr(CMAC_CTRL_OFS, 32'h1);
    wait_cycles(1);
    chk(rdata, 32'h3c);
    axi_rd(CMAC_STATUS_OFS, 32'h0, CMAC_RESP_OKAY);
    axi_wr(CMAC_ADDR_OFS, 32'h0);
    mem_cycle(1'b0, 11'h020, 8'h3c);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ======================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0; rrc = 1'b0; cwc = 1'b0; pl = 8'h00; host_data = 8'h00;
    kb_data = 7'h00; cursor_addr = 11'h000; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr_s = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_host;
    t_kb;
    t_copy_blank;
    t_eot;
    t_soft;
    test_done;
  end
  initial begin
    #200us;
    num_errors++;
    test_done;
  end
endmodule // testbench
